// File: verilog/wcmp_pkg.sv
// Constants and types for the weight target comparator.
// Assumes a 50 MHz system clock and weights from logic on that clock.
package wcmp_pkg;
    localparam int W = 24;
    localparam int WX = W + 2;
    localparam int CLK_HZ = 50_000_000;
    localparam int CMP_RATE_HZ = 50;
    localparam int TICK_CYC = CLK_HZ / CMP_RATE_HZ;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CMD = 8'h04;
    localparam logic [7:0] A_TARGET = 8'h08;
    localparam logic [7:0] A_SPILL = 8'h0C;
    localparam logic [7:0] A_FINE = 8'h10;
    localparam logic [7:0] A_TOLP = 8'h14;
    localparam logic [7:0] A_TOLN = 8'h18;
    localparam logic [7:0] A_LIMIT = 8'h1C;
    localparam logic [7:0] A_STAT = 8'h20;
    localparam logic [7:0] A_IRQS = 8'h24;
    localparam logic [7:0] A_IRQM = 8'h28;
    localparam logic [7:0] A_REC = 8'h2C;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int C_SRC_NET = 0;
    localparam int C_MODE = 1;
    localparam int C_SINGLE = 3;
    localparam int C_OUT = 4;
    localparam int C_SEC = 5;
    localparam int CTRL_W = 6;
    localparam logic [1:0] MODE_COINC = 2'h0;
    localparam logic [1:0] MODE_CONC = 2'h1;
    localparam int K_START = 0;
    localparam int K_PAUSE = 1;
    localparam int K_RESUME = 2;
    localparam int K_ABORT = 3;
    localparam int K_REC = 4;
    localparam int K_LOGIN = 5;
    localparam int K_LOGOUT = 6;
    localparam int I_DONE = 0;
    localparam int I_FAST = 1;
    localparam int I_BELOW = 2;
    localparam int I_DENY = 3;
    localparam int NIRQ = 4;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    localparam logic [W-1:0] WGT_RST = 24'h000000;
    localparam logic [NIRQ-1:0] IRQ_RST = 4'h0;
    typedef enum logic [1:0] {ST_READY, ST_RUN, ST_PAUSE} wcmp_state_t;
    typedef enum logic [1:0] {OU_OK, OU_UNDER, OU_OVER} wcmp_ou_t;
    typedef logic signed [WX-1:0] wcmp_wide_t;
    typedef struct packed {
        logic signed [W-1:0] gross;
        logic signed [W-1:0] net;
    } wcmp_weight_t;
endpackage

// File: verilog/wcmp_top.sv
// Weight target comparator: feed control, over/under and minimum check.
// Assumes weight_in comes from logic on clk_in and is always current.
//
// Notes on behaviour
// - Compare gross or net weight, as selected, against the target.
// - Comparisons run fifty times per second.
// - Below-minimum flag set while absolute net is under the limit.
// - A recorded weight carries an asterisk bit when below minimum.
// - With security on, limit writes need a logged-in user.
// - Coincidence outputs run freely: fine on below target minus spill, fast on below that minus fine-feed.
// - Concurrent mode starts both feeds, drops fast at slow point.
// - Fast feed stops at target minus fine-feed minus spill.
// - Independent mode holds fine feed off while fast feed runs.
// - Single-speed leaves fast feed unused; fine feed alone.
// - Latched feeds stop at target minus spill until next start.
// - Abort is accepted only while paused and ends the comparison.
// - Both weigh-in and weigh-out transfers are supported in the latched modes.
// - Each load is classed over, under or inside tolerance.
// - While paused both feed outputs are off.
// - Resume keeps the targets in effect before the pause.
// - Under below target minus tolerance, over above plus, else ok.
// - Start, pause and stop are ignored in coincidence mode.
`timescale 1ns/1ps
module wcmp_top
    import wcmp_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire wcmp_weight_t weight_in,
    output logic [31:0] rd_data_out,
    output logic fast_feed_out,
    output logic fine_feed_out,
    output logic below_min_out,
    output logic irq_out
);
    localparam int TW = $clog2(TICK_CYCLES + 1);

    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    logic [CTRL_W-1:0] ctrl_r;
    logic [W-1:0] target_r, spill_r, fine_amt_r, tolp_r, toln_r, limit_r;
    logic [W-1:0] tgt_s_r, spill_s_r, fine_s_r;
    wcmp_wide_t base_r;
    logic [TW-1:0] cnt_r;
    logic tick_r;
    wcmp_state_t st_r;
    logic fast_r, fine_r, fast_done_r, below_r, logged_r, irq_r;
    wcmp_ou_t ou_r;
    logic [NIRQ-1:0] irq_stat_r, irq_mask_r, ev;
    logic [W:0] rec_r;
    logic [31:0] rd_data_r;
    logic coinc, single, cmd_wr, lock;
    logic k_start, k_pause, k_resume, k_abort;
    logic signed [W-1:0] src;
    wcmp_wide_t srcx, amt, cut, fcut, ccut, cfcut, absn, netx, ou_lo, ou_hi;
    logic below_nxt;

    function automatic logic [31:0] z32(input logic [W-1:0] v);
        z32 = {{(32-W){1'b0}}, v};
    endfunction

    // ****************************************
    // Comparison arithmetic
    // ****************************************
    always_comb
    begin
        coinc = ctrl_r[C_MODE +: 2] == MODE_COINC;
        single = ctrl_r[C_SINGLE];
        cmd_wr = wr_in && addr_in == A_CMD;
        k_start = cmd_wr && wdata_in[K_START] && !coinc;
        k_pause = cmd_wr && wdata_in[K_PAUSE] && !coinc;
        k_resume = cmd_wr && wdata_in[K_RESUME] && !coinc;
        k_abort = cmd_wr && wdata_in[K_ABORT] && !coinc;
        lock = ctrl_r[C_SEC] && !logged_r;
        src = ctrl_r[C_SRC_NET] ? weight_in.net : weight_in.gross;
        srcx = wcmp_wide_t'(src);
        amt = ctrl_r[C_OUT] ? base_r - srcx : srcx;
        cut = wcmp_wide_t'(signed'(tgt_s_r)) - wcmp_wide_t'(signed'(spill_s_r));
        fcut = cut - wcmp_wide_t'(signed'(fine_s_r));
        ccut = wcmp_wide_t'(signed'(target_r)) - wcmp_wide_t'(signed'(spill_r));
        cfcut = ccut - wcmp_wide_t'(signed'(fine_amt_r));
        ou_lo = wcmp_wide_t'(signed'(target_r)) - wcmp_wide_t'(signed'(toln_r));
        ou_hi = wcmp_wide_t'(signed'(target_r)) + wcmp_wide_t'(signed'(tolp_r));
        netx = wcmp_wide_t'(weight_in.net);
        absn = netx < 0 ? -netx : netx;
        below_nxt = absn < wcmp_wide_t'(signed'(limit_r));
        ev = '0;
        ev[I_DONE] = st_r == ST_RUN && tick_r && !k_pause && !coinc && amt >= cut;
        ev[I_FAST] = st_r == ST_RUN && tick_r && !k_pause && !coinc && fast_r && amt >= fcut;
        ev[I_BELOW] = tick_r && below_nxt && !below_r;
        ev[I_DENY] = wr_in && addr_in == A_LIMIT && lock;
    end

    // ****************************************
    // Comparison rate
    // ****************************************
    // fifty per second
    always_ff @(posedge clk_in)
    begin
        if (rst_in || cnt_r == TW'(TICK_CYCLES - 1))
        begin
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
        end
        tick_r <= !rst_in && cnt_r == TW'(TICK_CYCLES - 1);
    end

    // ****************************************
    // Feed control
    // ****************************************
    // Targets are copied at start so edits mid-fill cannot move the cutoff.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st_r <= ST_READY;
            fast_r <= 1'b0;
            fine_r <= 1'b0;
            fast_done_r <= 1'b0;
            tgt_s_r <= WGT_RST;
            spill_s_r <= WGT_RST;
            fine_s_r <= WGT_RST;
            base_r <= '0;
        end
        else if (coinc)
        begin
            st_r <= ST_READY;
            if (tick_r)
            begin
                fine_r <= srcx < ccut;
                fast_r <= !single && srcx < cfcut;
            end
            // Leaving coincidence drops both feeds with the mode write, so a
            // latched mode never starts with two feeds left on
            if (wr_in && addr_in == A_CTRL && wdata_in[C_MODE +: 2] != MODE_COINC)
            begin
                fast_r <= 1'b0;
                fine_r <= 1'b0;
            end
        end
        else
        begin
            case (st_r)
                ST_READY:
                begin
                    fast_r <= 1'b0;
                    fine_r <= 1'b0;
                    if (k_start)
                    begin
                        st_r <= ST_RUN;
                        tgt_s_r <= target_r;
                        spill_s_r <= spill_r;
                        fine_s_r <= fine_amt_r;
                        base_r <= srcx;
                        fast_done_r <= single;
                        fast_r <= !single;
                        fine_r <= single || ctrl_r[C_MODE +: 2] == MODE_CONC;
                    end
                end
                ST_RUN:
                begin
                    if (k_pause)
                    begin
                        st_r <= ST_PAUSE;
                        fast_r <= 1'b0;
                        fine_r <= 1'b0;
                    end
                    else if (ev[I_DONE])
                    begin
                        st_r <= ST_READY;
                        fast_r <= 1'b0;
                        fine_r <= 1'b0;
                    end
                    else if (ev[I_FAST])
                    begin
                        fast_r <= 1'b0;
                        fast_done_r <= 1'b1;
                        fine_r <= 1'b1;
                    end
                    else if (single)
                    begin
                        fast_r <= 1'b0;
                    end
                end
                default:
                begin
                    fast_r <= 1'b0;
                    fine_r <= 1'b0;
                    if (k_abort)
                    begin
                        st_r <= ST_READY;
                    end
                    else if (k_resume)
                    begin
                        st_r <= ST_RUN;
                        fast_r <= !fast_done_r && !single;
                        fine_r <= fast_done_r || single
                            || ctrl_r[C_MODE +: 2] == MODE_CONC;
                    end
                end
            endcase
        end
    end

    paused_off_a: assert property (st_r == ST_PAUSE |-> !fast_r && !fine_r)
        else $error("feed active while paused");
    indep_excl_a: assert property (!coinc && ctrl_r[C_MODE +: 2] != MODE_CONC
        |-> !(fast_r && fine_r))
        else $error("both feeds on in independent mode");
    single_fast_a: assert property (!coinc && single && $past(single) |-> !fast_r)
        else $error("fast feed used in single speed");
    conc_start_a: assert property (st_r == ST_READY && k_start && !single
        && ctrl_r[C_MODE +: 2] == MODE_CONC |=> fast_r && fine_r && st_r == ST_RUN)
        else $error("concurrent start missed a feed");
    latch_hold_a: assert property (!coinc && st_r == ST_READY && !k_start
        |=> !fast_r && !fine_r)
        else $error("latched feed restarted without start");
    abort_only_a: assert property (st_r == ST_RUN && !k_pause && !ev[I_DONE]
        |=> st_r == ST_RUN || $past(coinc))
        else $error("comparison ended without cutoff or pause");
    resume_keep_a: assert property (st_r == ST_PAUSE && k_resume && !k_abort
        |=> st_r == ST_RUN && $stable(tgt_s_r) && $stable(spill_s_r))
        else $error("resume changed targets");
    fast_cut_a: assert property (ev[I_FAST] && !ev[I_DONE] |=> !fast_r ##1 !fast_r)
        else $error("fast feed not cut at slow point");
    pause_c: cover property (st_r == ST_RUN ##1 st_r == ST_PAUSE ##[1:20] st_r == ST_RUN);
    done_c: cover property (ev[I_FAST] ##[1:100] ev[I_DONE]);

    // ****************************************
    // Classification and minimum check
    // ****************************************
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            ou_r <= OU_OK;
            below_r <= 1'b0;
        end
        else if (tick_r)
        begin
            below_r <= below_nxt;
            if (srcx < ou_lo)
            begin
                ou_r <= OU_UNDER;
            end
            else if (srcx > ou_hi)
            begin
                ou_r <= OU_OVER;
            end
            else
            begin
                ou_r <= OU_OK;
            end
        end
    end

    below_clr_a: assert property (tick_r && netx >= 0
        && netx >= wcmp_wide_t'(signed'(limit_r)) |=> !below_r)
        else $error("below-minimum set at or above limit");
    ou_over_a: assert property (tick_r && srcx > ou_hi |=> ou_r == OU_OVER)
        else $error("over weight not classed over");
    below_c: cover property (tick_r && below_nxt ##1 below_r);

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            ctrl_r <= CTRL_RST;
            target_r <= WGT_RST;
            spill_r <= WGT_RST;
            fine_amt_r <= WGT_RST;
            tolp_r <= WGT_RST;
            toln_r <= WGT_RST;
            limit_r <= WGT_RST;
            irq_mask_r <= IRQ_RST;
        end
        else if (wr_in)
        begin
            if (addr_in == A_CTRL)
            begin
                ctrl_r <= wdata_in[CTRL_W-1:0];
            end
            else if (addr_in == A_TARGET)
            begin
                target_r <= wdata_in[W-1:0];
            end
            else if (addr_in == A_SPILL)
            begin
                spill_r <= wdata_in[W-1:0];
            end
            else if (addr_in == A_FINE)
            begin
                fine_amt_r <= wdata_in[W-1:0];
            end
            else if (addr_in == A_TOLP)
            begin
                tolp_r <= wdata_in[W-1:0];
            end
            else if (addr_in == A_TOLN)
            begin
                toln_r <= wdata_in[W-1:0];
            end
            else if (addr_in == A_LIMIT && !lock)
            begin
                limit_r <= wdata_in[W-1:0];
            end
            else if (addr_in == A_IRQM)
            begin
                irq_mask_r <= wdata_in[NIRQ-1:0];
            end
        end
    end

    limit_lock_a: assert property (wr_in && addr_in == A_LIMIT && lock
        |=> $stable(limit_r))
        else $error("limit changed without login");

    // Login state, weight record and sticky events; event set beats clear, logout beats login.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            logged_r <= 1'b0;
            rec_r <= '0;
            irq_stat_r <= IRQ_RST;
            irq_r <= 1'b0;
        end
        else
        begin
            if (cmd_wr && wdata_in[K_LOGOUT])
            begin
                logged_r <= 1'b0;
            end
            else if (cmd_wr && wdata_in[K_LOGIN])
            begin
                logged_r <= 1'b1;
            end
            if (cmd_wr && wdata_in[K_REC])
            begin
                rec_r <= {below_r, src};
            end
            irq_stat_r <= (irq_stat_r & ~((wr_in && addr_in == A_IRQS)
                ? wdata_in[NIRQ-1:0] : IRQ_RST)) | ev;
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    rec_flag_a: assert property (cmd_wr && wdata_in[K_REC] |=> rec_r[W] == $past(below_r))
        else $error("record lost below-minimum mark");

    // ****************************************
    // Register reads
    // ****************************************
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !rd_in)
        begin
            rd_data_r <= 32'h0;
        end
        else if (addr_in == A_CTRL)
        begin
            rd_data_r <= {{(32-CTRL_W){1'b0}}, ctrl_r};
        end
        else if (addr_in == A_TARGET)
        begin
            rd_data_r <= z32(target_r);
        end
        else if (addr_in == A_SPILL)
        begin
            rd_data_r <= z32(spill_r);
        end
        else if (addr_in == A_FINE)
        begin
            rd_data_r <= z32(fine_amt_r);
        end
        else if (addr_in == A_TOLP)
        begin
            rd_data_r <= z32(tolp_r);
        end
        else if (addr_in == A_TOLN)
        begin
            rd_data_r <= z32(toln_r);
        end
        else if (addr_in == A_LIMIT)
        begin
            rd_data_r <= z32(limit_r);
        end
        else if (addr_in == A_STAT)
        begin
            rd_data_r <= {23'h0, logged_r, ou_r, below_r, fine_r, fast_r, fast_done_r, st_r};
        end
        else if (addr_in == A_IRQS)
        begin
            rd_data_r <= {28'h0, irq_stat_r};
        end
        else if (addr_in == A_IRQM)
        begin
            rd_data_r <= {28'h0, irq_mask_r};
        end
        else if (addr_in == A_REC)
        begin
            rd_data_r <= {7'h0, rec_r};
        end
        else
        begin
            rd_data_r <= 32'h0;
        end
    end

    assign rd_data_out = rd_data_r;
    assign fast_feed_out = fast_r;
    assign fine_feed_out = fine_r;
    assign below_min_out = below_r;
    assign irq_out = irq_r;
endmodule // wcmp_top

// File: test/wcmp_feeder.sv
// Feeder model: turns the two feed outputs into a moving scale weight.
// Assumes feed outputs are registered on the same clock as the comparator.
`timescale 1ns/1ps
module wcmp_feeder
    import wcmp_pkg::*;
#(
    parameter logic [W-1:0] TARE = 24'h000010,
    parameter logic [W-1:0] FAST_STEP = 24'h000001,
    parameter logic [W-1:0] FINE_STEP = 24'h000001
)(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic fast_in,
    input wire logic fine_in,
    input wire logic out_in,
    input wire logic set_in,
    input wire logic [W-1:0] set_val_in,
    output wcmp_weight_t weight_out
);
    logic [W-1:0] gross_r;
    logic [W-1:0] step_nxt;

    always_comb
    begin
        step_nxt = (fast_in ? FAST_STEP : '0) + (fine_in ? FINE_STEP : '0);
    end

    // weigh-out removes material, weigh-in adds it
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            gross_r <= '0;
        else if (set_in)
            gross_r <= set_val_in;
        else if (out_in)
            gross_r <= gross_r - step_nxt;
        else
            gross_r <= gross_r + step_nxt;
    end

    // A fixed tare keeps net apart from gross, so the source select shows
    assign weight_out.gross = gross_r;
    assign weight_out.net = gross_r - TARE;
endmodule // wcmp_feeder

// File: test/wcmp_top_test.sv
// Self-checking bench for the weight target comparator.
// Assumes wcmp_top and the feeder model; a short tick keeps the run brief.
`timescale 1ns/1ps
module wcmp_top_test;
    import wcmp_pkg::*;
    localparam int TK = 8;
    typedef struct packed {
        logic [5:0] ctrl;
        logic [23:0] wgt;
        logic fine;
        logic fast;
        logic below;
        logic [1:0] ou;
    } wcmp_row_t;
    // Coincidence rows: target 0x64, spill 4, fine 0xA, tolerance 5, limit 0x20
    wcmp_row_t rows [10] = '{
        '{6'h00, 24'h000050, 1'b1, 1'b1, 1'b0, 2'h1},
        '{6'h00, 24'h000056, 1'b1, 1'b0, 1'b0, 2'h1},
        '{6'h00, 24'h00005F, 1'b1, 1'b0, 1'b0, 2'h0},
        '{6'h00, 24'h000060, 1'b0, 1'b0, 1'b0, 2'h0},
        '{6'h00, 24'h000069, 1'b0, 1'b0, 1'b0, 2'h0},
        '{6'h00, 24'h00006A, 1'b0, 1'b0, 1'b0, 2'h2},
        '{6'h08, 24'h000010, 1'b1, 1'b0, 1'b1, 2'h1},
        '{6'h00, 24'hFFFFF1, 1'b1, 1'b1, 1'b1, 2'h1},
        '{6'h00, 24'hFFFFF0, 1'b1, 1'b1, 1'b0, 2'h1},
        '{6'h01, 24'h00006F, 1'b1, 1'b0, 1'b0, 2'h0}};
    logic clk_in;
    logic rst_in;
    logic [7:0] addr_in;
    logic [31:0] wdata_in;
    logic wr_in;
    logic rd_in;
    logic [31:0] rd_data_out;
    logic fast_feed_out;
    logic fine_feed_out;
    logic below_min_out;
    logic irq_out;
    logic set_w;
    logic dir_out;
    logic [23:0] set_v;
    wcmp_weight_t wgt;
    logic [31:0] v;
    int err_count;
    int checks_done;

    wcmp_top #(.TICK_CYCLES(TK)) dut_u (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .weight_in(wgt),
        .rd_data_out(rd_data_out), .fast_feed_out(fast_feed_out),
        .fine_feed_out(fine_feed_out), .below_min_out(below_min_out), .irq_out(irq_out));
    wcmp_feeder feed_u (.clk_in(clk_in), .rst_in(rst_in), .fast_in(fast_feed_out),
        .fine_in(fine_feed_out), .out_in(dir_out), .set_in(set_w), .set_val_in(set_v),
        .weight_out(wgt));

    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // ****************************************
    // Bus, wait and compare tasks
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rd_data_out;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // Bounded wait for one feed output to drop
    task automatic wait_low(input int sel);
        int n;
        n = 0;
        while ((sel == 0 ? fast_feed_out : fine_feed_out) !== 1'b0 && n < 500)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check("wait_bound", n < 500, 32'h1);
    endtask

    task automatic settle;
        repeat (2 * TK + 2) @(posedge clk_in);
        #1;
    endtask

    task print_verdict;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        print_verdict;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        err_count = 0;
        checks_done = 0;
        rst_in = 1'b1;
        addr_in = 8'h00;
        wdata_in = 32'h00000000;
        wr_in = 1'b0;
        rd_in = 1'b0;
        set_w = 1'b1;
        dir_out = 1'b0;
        set_v = 24'h000000;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(A_CTRL, v);
        check("ctrl_rst", v, 32'h0);
        rd(A_STAT, v);
        check("stat_rst", v, 32'h0);
        rd(A_IRQS, v);
        check("irqs_rst", v, 32'h0);
        rd(8'h30, v);
        check("unmapped", v, 32'h0);
        check("outs_rst", {fast_feed_out, fine_feed_out, below_min_out, irq_out}, 32'h0);
        wr(A_TARGET, 32'h64);
        wr(A_SPILL, 32'h4);
        wr(A_FINE, 32'hA);
        wr(A_TOLP, 32'h5);
        wr(A_TOLN, 32'h5);
        wr(A_LIMIT, 32'h20);
        for (int i = 0; i < 10; i++)
        begin
            wr(A_CTRL, {26'h0, rows[i].ctrl});
            set_v <= rows[i].wgt;
            settle;
            check("fine", fine_feed_out, rows[i].fine);
            check("fast", fast_feed_out, rows[i].fast);
            check("below", below_min_out, rows[i].below);
            rd(A_STAT, v);
            check("ou", v[7:6], rows[i].ou);
        end
        wr(A_CMD, 32'h1 << K_START);
        rd(A_STAT, v);
        check("coinc_start", v[1:0], 32'h0);
        wr(A_CTRL, 32'h08);
        set_v <= 24'h000010;
        settle;
        wr(A_CMD, 32'h1 << K_REC);
        rd(A_REC, v);
        check("record", v, 32'h01000010);
        // Concurrent weigh-in run with the feeder filling the scale
        set_v <= 24'h000000;
        wr(A_CTRL, 32'h02);
        wr(A_IRQS, 32'hF);
        set_w <= 1'b0;
        wr(A_CMD, 32'h1 << K_START);
        check("conc_start", {fast_feed_out, fine_feed_out}, 32'h3);
        wait_low(0);
        check("conc_fine", fine_feed_out, 32'h1);
        check("fast_cut", $signed(wgt.gross) >= 86, 32'h1);
        wait_low(1);
        check("fine_cut", $signed(wgt.gross) >= 96, 32'h1);
        rd(A_STAT, v);
        check("run_end", v[1:0], 32'h0);
        rd(A_IRQS, v);
        check("irq_stat", v[1:0], 32'h3);
        check("irq_masked", irq_out, 32'h0);
        wr(A_IRQM, 32'h3);
        repeat (2) @(posedge clk_in);
        #1;
        check("irq_on", irq_out, 32'h1);
        wr(A_IRQS, 32'h3);
        repeat (2) @(posedge clk_in);
        #1;
        check("irq_clr", irq_out, 32'h0);
        wr(A_IRQM, 32'h0);
        set_w <= 1'b1;
        set_v <= 24'h000010;
        settle;
        check("latched", {fast_feed_out, fine_feed_out}, 32'h0);
        // Independent run with refused abort, pause, resume and abort
        set_v <= 24'h000000;
        wr(A_CTRL, 32'h04);
        set_w <= 1'b0;
        wr(A_CMD, 32'h1 << K_START);
        check("ind_start", {fast_feed_out, fine_feed_out}, 32'h2);
        wr(A_CMD, 32'h1 << K_ABORT);
        rd(A_STAT, v);
        check("abort_run", {fast_feed_out, v[1:0]}, 32'h5);
        wr(A_CMD, 32'h1 << K_PAUSE);
        check("paused_off", {fast_feed_out, fine_feed_out}, 32'h0);
        rd(A_STAT, v);
        check("paused", v[1:0], 32'h2);
        wr(A_TARGET, 32'h400);
        wr(A_CMD, 32'h1 << K_RESUME);
        wait_low(0);
        check("ind_fine", fine_feed_out, 32'h1);
        check("old_target", $signed(wgt.gross) < 128, 32'h1);
        wr(A_CMD, 32'h1 << K_PAUSE);
        wr(A_CMD, 32'h1 << K_ABORT);
        wr(A_CMD, 32'h1 << K_RESUME);
        rd(A_STAT, v);
        check("aborted", {fast_feed_out, fine_feed_out, v[1:0]}, 32'h0);
        wr(A_TARGET, 32'h64);
        // Weigh-out run: removed amount is compared
        set_w <= 1'b1;
        set_v <= 24'h0000C8;
        dir_out <= 1'b1;
        wr(A_CTRL, 32'h12);
        set_w <= 1'b0;
        wr(A_CMD, 32'h1 << K_START);
        wait_low(1);
        check("wout_cut", $signed(wgt.gross) <= 104, 32'h1);
        dir_out <= 1'b0;
        set_w <= 1'b1;
        // Limit writes under security
        set_v <= 24'h000050;
        wr(A_CTRL, 32'h20);
        settle;
        wr(A_IRQS, 32'hF);
        wr(A_LIMIT, 32'h55);
        rd(A_LIMIT, v);
        check("limit_deny", v, 32'h20);
        rd(A_IRQS, v);
        check("deny_irq", v[3], 32'h1);
        wr(A_CMD, 32'h1 << K_LOGIN);
        wr(A_LIMIT, 32'h55);
        rd(A_LIMIT, v);
        check("limit_ok", v, 32'h55);
        wr(A_CMD, 32'h1 << K_LOGOUT);
        // Single-speed latched run, then a reset in mid-run
        set_v <= 24'h000000;
        wr(A_CTRL, 32'h0C);
        set_w <= 1'b0;
        wr(A_CMD, 32'h1 << K_START);
        check("single_start", {fast_feed_out, fine_feed_out}, 32'h1);
        wait_low(1);
        check("single_cut", $signed(wgt.gross) >= 96, 32'h1);
        set_w <= 1'b1;
        wr(A_CMD, 32'h1 << K_START);
        check("single_run", fine_feed_out, 32'h1);
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        check("rst_outs", {fast_feed_out, fine_feed_out, below_min_out, irq_out}, 32'h0);
        rd(A_STAT, v);
        check("rst_stat", v, 32'h0);
        rd(A_LIMIT, v);
        check("rst_limit", v, 32'h0);
        print_verdict;
    end
endmodule // wcmp_top_test
